// ---- sfpm_buf2.sv ----
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes both sides run on MCLK.
 */
`timescale 1ns/1ps
module sfpm_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    logic [W-1:0] mem_r [2];
    logic         wr_ptr_r;
    logic         rd_ptr_r;
    logic [1:0]   cnt_r;
    wire          push = in_valid & in_ready;
    wire          pop  = out_valid & out_ready;

    // ************************************************************
    // flags
    // ************************************************************
    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rd_ptr_r];

    // storage has no reset; cnt_r guards every read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            cnt_r    <= 2'h0;
        end else begin
            wr_ptr_r <= wr_ptr_r ^ push;
            rd_ptr_r <= rd_ptr_r ^ pop;
            cnt_r    <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ---- sfpm_chk.sv ----
/*
 * Checker for the paused serial link, watching the shared wires.
 * Assumes pins are sampled on MCLK and RESET is synchronous.
 */
`timescale 1ns/1ps
module sfpm_chk (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic pause_n,
    input wire logic so_o,
    input wire logic so_oe,
    input wire logic so
);
    // ****************************************
    // wire relations
    // ****************************************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);

    // pause taken with clock low, held past the pin syncs
    sequence s_pause_in;
        !cs_n && !sck && $fell(pause_n) ##1 (!pause_n && !cs_n)[*4];
    endsequence
    // select taken with no pause pending
    sequence s_sel_in;
        $fell(cs_n) ##1 (!cs_n && pause_n)[*4];
    endsequence

    a_pause_float: assert property (s_pause_in |=> !so_oe)
        else $error("output driven in pause");
    a_pause_quiet: assert property (
        (!pause_n && !cs_n)[*8] |-> $stable(so_o) && !$rose(so_oe))
        else $error("output moved in pause");
    a_resume_drive: assert property (
        $rose(pause_n) && !cs_n && !sck |-> ##[3:8] so_oe)
        else $error("no resume after pause");
    a_desel_float: assert property (cs_n[*5] |-> !so_oe)
        else $error("output driven while deselected");
    a_sel_drive: assert property (s_sel_in |-> so_oe)
        else $error("output not driven after select");
    a_host_enter: assert property (
        $fell(pause_n) |-> !sck && !cs_n)
        else $error("pause with clock high or deselected");
    a_host_leave: assert property (
        $rose(pause_n) && $stable(cs_n) && !cs_n |-> !sck)
        else $error("release with clock high");
    a_host_clock: assert property ($rose(sck) |-> pause_n && !cs_n)
        else $error("clocking while paused");
    a_so_edge: assert property (so_oe && $changed(so_o) |-> !sck)
        else $error("output moved with clock high");
    a_si_steady: assert property ($changed(si) && !cs_n |-> !sck)
        else $error("input moved with clock high");
endmodule

// ---- sfpm_dev.sv ----
/*
 * Flash end of the link: samples the host's pins on MCLK, shifts
 * bytes in and out, honours the pause pin and maps the first three
 * bytes of a frame onto pages and erase blocks of the array.
 * Assumes a host that keeps the serial clock at or below MCLK/8.
 */
`timescale 1ns/1ps

module sfpm_dev (
    input  wire logic              MCLK,
    input  wire logic              RESET,
    sfpm_link_if.dev               LINK,
    input  wire logic [7:0]        TX_DATA,
    output logic                   TX_TAKEN,
    output logic [7:0]             RX_DATA,
    output logic                   RX_VALID,
    output logic                   SELECTED,
    output logic                   PAUSED,
    input  sfpm_pkg::sfpm_erase_t  ERASE_SEL,
    output logic                   ADDR_VALID,
    output logic [22:0]            ADDR,
    output logic [22:0]            ERASE_BASE,
    output logic [22:0]            ERASE_LAST,
    output logic [15:0]            PAGE_INDEX,
    output logic [7:0]             PAGE_OFFSET,
    output logic [8:0]             PAGE_FILL
);
    typedef enum logic [1:0] {
        D_IDLE, D_ACTIVE, D_PAUSED
    } sfpm_dstate_t;

    sfpm_dstate_t st_r;
    sfpm_dstate_t st_nxt;
    logic [3:0]   s1_r;
    logic [3:0]   s2_r;
    logic         sck_p_r;
    logic         pause_p_r;
    logic [2:0]   bit_r;
    logic [6:0]   rx_sh_r;
    logic [7:0]   tx_sh_r;
    logic         load_pend_r;
    logic [1:0]   byte_idx_r;
    logic [15:0]  addr_sh_r;
    logic [22:0]  page_ptr_r;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    // every pin is asynchronous to MCLK; all four share one depth so
    // the relative order of clock and pause edges is preserved
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            s1_r <= sfpm_pkg::PIN_SYNC_RST;
            s2_r <= sfpm_pkg::PIN_SYNC_RST;
        end else begin
            s1_r <= {LINK.cs_n, LINK.sck, LINK.si, LINK.pause_n};
            s2_r <= s1_r;
        end
    end

    // previous synchronised levels for edge finding
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            sck_p_r   <= 1'b0;
            pause_p_r <= 1'b1;
        end else begin
            sck_p_r   <= s2_r[2];
            pause_p_r <= s2_r[0];
        end
    end

    // ************************************************************
    // edge decode
    // ************************************************************
    wire cs_n_s     = s2_r[3];
    wire sck_s      = s2_r[2];
    wire si_s       = s2_r[1];
    wire pause_n_s  = s2_r[0];
    wire sck_rise   = sck_s & ~sck_p_r;
    wire sck_fall   = ~sck_s & sck_p_r;
    wire pause_fall = ~pause_n_s & pause_p_r;
    wire pause_rise = pause_n_s & ~pause_p_r;
    wire active     = (st_r == D_ACTIVE);
    wire start      = (st_r == D_IDLE) & ~cs_n_s;
    wire shift_in   = active & sck_rise;
    wire shift_out  = active & sck_fall;
    wire byte_done  = shift_in & (bit_r == 3'h7);
    wire tx_load    = start | (shift_out & load_pend_r);
    wire [7:0] rx_byte  = {rx_sh_r, si_s};
    wire addr_byte  = byte_done & (byte_idx_r != 2'(sfpm_pkg::ADDR_BYTES));
    wire addr_last  = addr_byte & (byte_idx_r == 2'(sfpm_pkg::ADDR_BYTES - 1));
    wire data_byte  = byte_done & ~addr_byte;
    wire [23:0] addr_full = {addr_sh_r, rx_byte}; // bit 23 is dropped

    assign TX_TAKEN   = tx_load;
    assign SELECTED   = (st_r != D_IDLE);
    assign PAUSED     = (st_r == D_PAUSED);
    assign LINK.so_o  = tx_sh_r[7];
    assign LINK.so_oe = active;

    // ************************************************************
    // pause state machine
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            D_IDLE: begin
                // pause edges while deselected fall through here
                if (!cs_n_s) begin
                    st_nxt = D_ACTIVE;
                end
            end
            D_ACTIVE: begin
                if (pause_fall && !sck_s) begin
                    st_nxt = D_PAUSED;
                end
            end
            D_PAUSED: begin
                // a release with the clock high is not honoured
                if (pause_rise && !sck_s) begin
                    st_nxt = D_ACTIVE;
                end else begin
                    st_nxt = D_PAUSED;
                end
            end
        endcase
        if (cs_n_s) begin
            st_nxt = D_IDLE;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st_r <= D_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // bit shifter
    // ************************************************************
    // counters move only in the active state, so a pause freezes
    // them at the bit it interrupted
    always_ff @(posedge MCLK) begin
        if (RESET || cs_n_s) begin
            bit_r       <= 3'h0;
            rx_sh_r     <= 7'h00;
            load_pend_r <= 1'b0;
        end else if (shift_in) begin
            bit_r       <= bit_r + 3'h1;
            rx_sh_r     <= rx_byte[6:0];
            load_pend_r <= (bit_r == 3'h7);
        end else if (shift_out) begin
            load_pend_r <= 1'b0;
        end
    end

    // output byte: first bit is ready before the first clock edge
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            tx_sh_r <= sfpm_pkg::FILL_BYTE;
        end else if (tx_load) begin
            tx_sh_r <= TX_DATA;
        end else if (shift_out) begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b1};
        end
    end

    // received byte, one-cycle strobe
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            RX_DATA  <= 8'h00;
            RX_VALID <= 1'b0;
        end else begin
            RX_VALID <= byte_done;
            if (byte_done) begin
                RX_DATA <= rx_byte;
            end
        end
    end

    // ************************************************************
    // address capture and page fill
    // ************************************************************
    // the fill pointer wraps inside the page, so a long burst lands
    // on the start of the same page rather than the next one
    always_ff @(posedge MCLK) begin
        if (RESET || cs_n_s) begin
            byte_idx_r <= 2'h0;
            addr_sh_r  <= 16'h0000;
            ADDR_VALID <= 1'b0;
            PAGE_FILL  <= 9'h000;
        end else if (addr_byte) begin
            byte_idx_r <= byte_idx_r + 2'h1;
            addr_sh_r  <= {addr_sh_r[7:0], rx_byte};
            ADDR_VALID <= addr_last;
        end else if (data_byte && PAGE_FILL != 9'(sfpm_pkg::PAGE_SIZE)) begin
            PAGE_FILL  <= PAGE_FILL + 9'h001;
        end
    end

    // address register survives deselect for the user to read
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ADDR       <= 23'h000000;
            page_ptr_r <= 23'h000000;
        end else if (addr_last) begin
            ADDR       <= addr_full[22:0] & sfpm_pkg::ARRAY_TOP;
            page_ptr_r <= addr_full[22:0] & sfpm_pkg::ARRAY_TOP;
        end else if (data_byte) begin
            page_ptr_r <= {page_ptr_r[22:8], page_ptr_r[7:0] + 8'h01};
        end
    end

    // ************************************************************
    // erase block and page mapping
    // ************************************************************
    wire [22:0] er_mask =
        (ERASE_SEL == sfpm_pkg::SFPM_ER_4K)  ? sfpm_pkg::BLK4K_MASK  :
        (ERASE_SEL == sfpm_pkg::SFPM_ER_32K) ? sfpm_pkg::BLK32K_MASK :
        (ERASE_SEL == sfpm_pkg::SFPM_ER_64K) ? sfpm_pkg::BLK64K_MASK :
                                               sfpm_pkg::ARRAY_TOP;
    wire [22:0] page_idx_w = ADDR >> sfpm_pkg::PAGE_SHIFT;

    // blocks are naturally aligned, so base and last are pure masks
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ERASE_BASE  <= 23'h000000;
            ERASE_LAST  <= 23'h000000;
            PAGE_INDEX  <= 16'h0000;
            PAGE_OFFSET <= 8'h00;
        end else begin
            ERASE_BASE  <= ADDR & ~er_mask;
            ERASE_LAST  <= (ADDR | er_mask) & sfpm_pkg::ARRAY_TOP;
            PAGE_INDEX  <= page_idx_w[15:0];
            PAGE_OFFSET <= page_ptr_r[7:0];
        end
    end
endmodule

// ---- sfpm_host.sv ----
/*
 * Host end of the link: makes the serial clock by dividing MCLK,
 * frames bytes from a two-entry buffer and pauses on request.
 * Assumes the flash end shifts on the clock edges it sees.
 */
`timescale 1ns/1ps
module sfpm_host #(
    parameter int HALF = sfpm_pkg::SCK_HALF_CYC
) (
    input  wire logic  MCLK,
    input  wire logic  RESET,
    sfpm_link_if.host  LINK,
    input  wire logic [7:0] TX_DATA,
    input  wire logic  TX_VALID,
    output logic       TX_READY,
    input  wire logic  FRAME_EN,
    input  wire logic  PAUSE_REQ,
    output logic [7:0] RX_DATA,
    output logic       RX_VALID,
    output logic       BUSY,
    output logic       PAUSED
);
    typedef enum logic [2:0] {
        H_IDLE, H_SETUP, H_LOAD, H_LOW, H_HIGH, H_PAUSE, H_RESUME,
        H_DESEL
    } sfpm_hstate_t;

    sfpm_hstate_t st_r;
    logic [7:0]   cnt_r;
    logic [2:0]   bit_r;
    logic [7:0]   tx_sh_r;
    logic [7:0]   rx_sh_r;
    logic         cs_n_r;
    logic         sck_r;
    logic         si_r;
    logic         pause_n_r;
    logic         so_s1_r;
    logic         so_s2_r;
    logic [7:0]   b_data;
    logic         b_valid;

    // ************************************************************
    // decode
    // ************************************************************
    wire half_done  = (cnt_r == 8'(HALF - 1));
    wire guard_done = (cnt_r == 8'(sfpm_pkg::PAUSE_GUARD_CYC - 1));
    wire desel_done = (cnt_r == 8'(sfpm_pkg::DESEL_CYC - 1));
    wire b_pop      = (st_r == H_LOAD) & FRAME_EN & b_valid;
    wire byte_end   = (st_r == H_HIGH) & half_done & (bit_r == 3'h7);
    wire [7:0] rx_next = {rx_sh_r[6:0], so_s2_r};

    assign LINK.cs_n    = cs_n_r;
    assign LINK.sck     = sck_r;
    assign LINK.si      = si_r;
    assign LINK.pause_n = pause_n_r;
    assign BUSY         = (st_r != H_IDLE);
    assign PAUSED       = (st_r == H_PAUSE);

    // user bytes wait here; a stall stops the clock, not the data
    sfpm_buf2 #(.W(8)) u_txbuf (
        .clk       (MCLK),
        .rst       (RESET),
        .in_data   (TX_DATA),
        .in_valid  (TX_VALID),
        .in_ready  (TX_READY),
        .out_data  (b_data),
        .out_valid (b_valid),
        .out_ready (b_pop)
    );

    // serial output crosses in from the flash side
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            so_s1_r <= 1'b1;
            so_s2_r <= 1'b1;
        end else begin
            so_s1_r <= LINK.so;
            so_s2_r <= so_s1_r;
        end
    end

    // ************************************************************
    // frame sequencer
    // ************************************************************
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st_r      <= H_IDLE;
            cnt_r     <= 8'h00;
            bit_r     <= 3'h0;
            tx_sh_r   <= 8'h00;
            rx_sh_r   <= 8'h00;
            cs_n_r    <= 1'b1;
            sck_r     <= 1'b0;
            si_r      <= 1'b0;
            pause_n_r <= 1'b1;
            RX_DATA   <= 8'h00;
            RX_VALID  <= 1'b0;
        end else begin
            cnt_r    <= cnt_r + 8'h01;
            RX_VALID <= byte_end;
            unique case (st_r)
                H_IDLE: begin
                    if (FRAME_EN & b_valid) begin
                        cs_n_r <= 1'b0;
                        cnt_r  <= 8'h00;
                        st_r   <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    if (half_done) begin
                        st_r <= H_LOAD;
                    end
                end
                H_LOAD: begin
                    if (!FRAME_EN) begin
                        cs_n_r <= 1'b1;
                        cnt_r  <= 8'h00;
                        st_r   <= H_DESEL;
                    end else if (b_valid) begin
                        tx_sh_r <= b_data;
                        si_r    <= b_data[7];
                        bit_r   <= 3'h0;
                        cnt_r   <= 8'h00;
                        st_r    <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (half_done && PAUSE_REQ) begin
                        pause_n_r <= 1'b0;
                        cnt_r     <= 8'h00;
                        st_r      <= H_PAUSE;
                    end else if (half_done) begin
                        sck_r <= 1'b1;
                        cnt_r <= 8'h00;
                        st_r  <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (half_done) begin
                        sck_r   <= 1'b0;
                        rx_sh_r <= rx_next;
                        bit_r   <= bit_r + 3'h1;
                        cnt_r   <= 8'h00;
                        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                        si_r    <= tx_sh_r[6];
                        st_r    <= (bit_r == 3'h7) ? H_LOAD : H_LOW;
                        if (bit_r == 3'h7) begin
                            RX_DATA <= rx_next;
                        end
                    end
                end
                H_PAUSE: begin
                    // dropping the frame here abandons it at the flash
                    if (!FRAME_EN) begin
                        cs_n_r    <= 1'b1;
                        pause_n_r <= 1'b1;
                        cnt_r     <= 8'h00;
                        st_r      <= H_DESEL;
                    end else if (!PAUSE_REQ && cnt_r >= 8'(HALF - 1)) begin
                        pause_n_r <= 1'b1;
                        cnt_r     <= 8'h00;
                        st_r      <= H_RESUME;
                    end
                end
                H_RESUME: begin
                    if (guard_done) begin
                        cnt_r <= 8'h00;
                        st_r  <= H_LOW;
                    end
                end
                H_DESEL: begin
                    if (desel_done) begin
                        st_r <= H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ---- sfpm_link_if.sv ----
/*
 * Four-wire serial link with the active-low pause pin, joining the
 * host end and the flash end. Assumes no third party drives it.
 */
`timescale 1ns/1ps
interface sfpm_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic pause_n;   // quad_data_line_3 in its pause role
    logic so_o;
    logic so_oe;
    logic so;

    // serial output floats high when the flash lets go of it
    assign so = so_oe ? so_o : 1'b1;

    modport dev (
        input  cs_n,
        input  sck,
        input  si,
        input  pause_n,
        output so_o,
        output so_oe
    );

    modport host (
        output cs_n,
        output sck,
        output si,
        output pause_n,
        input  so
    );
endinterface

// ---- sfpm_pkg.sv ----
/*
 * Shared constants for the paused serial flash link: link timing,
 * array geometry of the flash and the erase granularity encoding.
 * Assumes both link ends and the bench use MCLK at 25 MHz.
 */
package sfpm_pkg;

    // ************************************************************
    // link timing, in MCLK cycles, and frame sizes
    // ************************************************************
    localparam int SCK_HALF_CYC    = 8;   // host-made clock, 16 cycles
    localparam int DESEL_CYC       = 8;   // select high between frames
    localparam int PAUSE_GUARD_CYC = 4;   // pause pin settle, syncs are 2
    localparam int BYTE_BITS       = 8;
    localparam int ADDR_BYTES      = 3;

    // ************************************************************
    // array geometry
    // ************************************************************
    localparam int          ADDR_W       = 23;
    localparam logic [22:0] ARRAY_TOP    = 23'h7fffff;
    localparam int          PAGE_SHIFT   = 8;
    localparam int          PAGE_SIZE    = 256;
    localparam int          PAGE_COUNT   = 65536;
    localparam int          BLK4K_SHIFT  = 12;
    localparam int          BLK32K_SHIFT = 15;
    localparam int          BLK64K_SHIFT = 16;
    localparam logic [22:0] BLK4K_MASK   = 23'h000fff;
    localparam logic [22:0] BLK32K_MASK  = 23'h007fff;
    localparam logic [22:0] BLK64K_MASK  = 23'h00ffff;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [3:0] PIN_SYNC_RST = 4'h9; // cs_n,sck,si,pause_n
    localparam logic [7:0] FILL_BYTE    = 8'hff;

    // erase granularity chosen by the user side
    typedef enum logic [1:0] {
        SFPM_ER_4K,
        SFPM_ER_32K,
        SFPM_ER_64K,
        SFPM_ER_CHIP
    } sfpm_erase_t;

endpackage

// ---- test_serial_flash_pause_and_array_map.sv ----
/*
 * Bench joining host and flash ends over the link interface.
 * Assumes MCLK of 40 ns and the package constants of the block.
 */
`timescale 1ns/1ps
module test_serial_flash_pause_and_array_map;
    logic                  mclk, reset, h_txv, h_txr, fr_en, p_req;
    logic                  h_rxv, h_busy, h_psd, d_tkn, d_rxv;
    logic                  d_sel, d_psd, d_av;
    logic [7:0]            h_tx, h_rx, d_tx, d_rx, d_po;
    logic [22:0]           d_addr, d_eb, d_el;
    logic [15:0]           d_pi;
    logic [8:0]            d_pf;
    sfpm_pkg::sfpm_erase_t er_sel;
    logic [31:0]           rnd;
    logic [7:0]            dq[$], hq[$], sq[$];
    int                    failures, checks_done;

    sfpm_link_if lnk();
    sfpm_host i_sfpm_host (.MCLK(mclk), .RESET(reset), .LINK(lnk),
        .TX_DATA(h_tx), .TX_VALID(h_txv), .TX_READY(h_txr),
        .FRAME_EN(fr_en), .PAUSE_REQ(p_req), .RX_DATA(h_rx),
        .RX_VALID(h_rxv), .BUSY(h_busy), .PAUSED(h_psd));
    sfpm_dev i_sfpm_dev (.MCLK(mclk), .RESET(reset), .LINK(lnk),
        .TX_DATA(d_tx), .TX_TAKEN(d_tkn), .RX_DATA(d_rx),
        .RX_VALID(d_rxv), .SELECTED(d_sel), .PAUSED(d_psd),
        .ERASE_SEL(er_sel), .ADDR_VALID(d_av), .ADDR(d_addr),
        .ERASE_BASE(d_eb), .ERASE_LAST(d_el), .PAGE_INDEX(d_pi),
        .PAGE_OFFSET(d_po), .PAGE_FILL(d_pf));
    sfpm_chk i_sfpm_chk (.MCLK(mclk), .RESET(reset), .cs_n(lnk.cs_n),
        .sck(lnk.sck), .si(lnk.si), .pause_n(lnk.pause_n),
        .so_o(lnk.so_o), .so_oe(lnk.so_oe), .so(lnk.so));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] nxt();
        repeat (8) rnd = {rnd[30:0], rnd[31]^rnd[21]^rnd[1]^rnd[0]};
        return rnd[7:0];
    endfunction
    function automatic logic [22:0] emask(int s);
        case (s)
            0: return sfpm_pkg::BLK4K_MASK;
            1: return sfpm_pkg::BLK32K_MASK;
            2: return sfpm_pkg::BLK64K_MASK;
            default: return sfpm_pkg::ARRAY_TOP;
        endcase
    endfunction
    task tick;
        @(posedge mclk);
        #1;
    endtask
    task chk(input logic [22:0] g, input logic [22:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: %s %h/%h", $time, m, g, e);
        end
    endtask
    task chk_q(input logic [7:0] g[$], input logic [7:0] e[$]);
        chk(23'(g.size()), 23'(e.size()), "stream length");
        for (int i = 0; i < g.size() && i < e.size(); i++)
            chk(23'(g[i]), 23'(e[i]), "stream byte");
    endtask
    task test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // valid stays up between back-to-back bytes
    task push(input logic [7:0] b);
        int n;
        h_tx = b;
        h_txv = 1'b1;
        for (n = 0; n < 4000 && h_txr !== 1'b1; n++) tick;
        tick;
    endtask
    task pause(input int md);
        int k;
        h_txv = 1'b0;
        p_req = 1'b1;
        for (k = 0; k < 200 && h_psd !== 1'b1; k++) tick;
        repeat (8) tick;
        chk(23'(d_psd), 23'h1, "flash paused");
        k = dq.size();
        repeat (40) tick;
        chk(23'(dq.size()), 23'(k), "bytes in pause");
        chk(23'(d_psd), 23'h1, "pause held");
        chk(23'(lnk.so_oe), 23'h0, "float in pause");
        if (md == 2) begin
            fr_en = 1'b0;
            for (k = 0; k < 200 && h_busy !== 1'b0; k++) tick;
            repeat (4) tick;
            chk(23'({d_sel, d_psd, d_av}), 23'h0, "abort");
            // the aborted frame leaves bytes queued; reset flushes them
            reset = 1'b1;
            repeat (2) tick;
            reset = 1'b0;
            tick;
            chk(23'({h_txr, h_busy, d_sel}), 23'h4, "reset mid-run");
        end
        p_req = 1'b0;
    endtask
    // md: 0 plain, 1 pause mid-frame, 2 pause then deselect
    task frame(input logic [22:0] a, input int n, input int md);
        logic [7:0] b;
        logic [7:0] ex[$];
        int k;
        dq.delete();
        hq.delete();
        ex.delete();
        sq.delete();
        for (int i = 0; i < n + 3; i++) begin
            b = nxt();
            if (i == 0) b[6:0] = a[22:16];
            if (i == 1) b = a[15:8];
            if (i == 2) b = a[7:0];
            if (i == 2) chk(23'(h_txr), 23'h0, "buffer full");
            if (i == 2) fr_en = 1'b1;
            if (md != 0 && i == 3) pause(md);
            if (md == 2 && i == 3) break;
            ex.push_back(b);
            push(b);
        end
        h_txv = 1'b0;
        if (md != 2) begin
            for (k = 0; k < 9000 && dq.size() < n + 3; k++) tick;
            // host takes its last byte some cycles after the flash
            repeat (8) tick;
            chk_q(dq, ex);
            while (sq.size() > n + 3) void'(sq.pop_back());
            chk_q(hq, sq);
            chk(d_addr, a, "address");
            chk(23'(d_av), 23'h1, "address valid");
            chk(23'(d_pi), 23'(a[22:8]), "page index");
            chk(23'(d_po), 23'(8'(a[7:0] + n)), "page offset");
            chk(23'(d_pf), 23'(n), "page fill");
            for (int s = 0; s < 4; s++) begin
                er_sel = sfpm_pkg::sfpm_erase_t'(s);
                repeat (3) tick;
                chk(d_eb, a & ~emask(s), "erase base");
                chk(d_el, a | emask(s), "erase last");
            end
        end
        fr_en = 1'b0;
        for (k = 0; k < 200 && h_busy !== 1'b0; k++) tick;
        repeat (10) tick;
        $display("frame %h mode %0d done", a, md);
    endtask

    // ****************************************
    // clock, feeds, monitors, sequence
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // next reply byte handed over whenever the flash takes one
    always @(posedge mclk) begin
        if (d_tkn === 1'b1) begin
            sq.push_back(d_tx);
            d_tx <= #1 nxt();
        end
        if (d_rxv === 1'b1) dq.push_back(d_rx);
        if (h_rxv === 1'b1) hq.push_back(h_rx);
    end
    // hang guard, far beyond the longest frame list
    initial begin
        #(40 * 80000);
        failures++;
        test_done;
    end
    initial begin
        rnd = 32'hb3e19def;
        {reset, h_txv, fr_en, p_req} = 4'h8;
        h_tx = 8'h00;
        d_tx = 8'h5a;
        er_sel = sfpm_pkg::SFPM_ER_4K;
        repeat (2) tick;
        reset = 1'b0;
        tick;
        chk(23'({lnk.cs_n, lnk.sck, lnk.pause_n, lnk.so_oe, h_txr,
            h_busy}), 23'h2a, "reset state");
        frame(23'({nxt(), nxt(), nxt()}), 2, 0);
        frame(23'h7ffffe, 4, 0);
        frame(23'({nxt(), nxt(), nxt()}), 1, 2);
        frame(23'({nxt(), nxt(), nxt()}), 3, 1);
        for (int j = 0; j < 3; j++)
            frame(23'({nxt(), nxt(), nxt()}), 1 + nxt() % 4, j % 2);
        frame(23'h000000, 1, 0);
        test_done;
    end
endmodule
